// ### inc/keu_pkg.sv
// Constants, register map and carrier types of the external and keypad interrupt unit
`default_nettype none

package keu_pkg;

  // Register map, byte addresses on the 8-bit register port
  localparam logic [7:0] KEU_SCR_OFS    = 8'h1a;
  localparam logic [7:0] KEU_PIN_EN_OFS = 8'h1b;

  // Status/control register fields
  localparam int KEU_SCR_EXT_FLAG_BIT  = 7;
  localparam int KEU_SCR_EXT_ACK_BIT   = 6;
  localparam int KEU_SCR_EXT_MASK_BIT  = 5;
  localparam int KEU_SCR_EXT_TRIG_BIT  = 4;
  localparam int KEU_SCR_KEY_FLAG_BIT  = 3;
  localparam int KEU_SCR_KEY_ACK_BIT   = 2;
  localparam int KEU_SCR_KEY_MASK_BIT  = 1;
  localparam int KEU_SCR_KEY_TRIG_BIT  = 0;

  // Keypad pin-enable register: six enables in bits 6..1
  localparam int KEU_KEY_PINS      = 6;
  localparam int KEU_PIN_EN_LSB    = 1;
  localparam int KEU_PIN_EN_MSB    = 6;

  // Reset values
  localparam logic                    KEU_CTRL_RST   = 1'b0;
  localparam logic [KEU_KEY_PINS-1:0] KEU_PIN_EN_RST = 6'h00;
  localparam logic [7:0]              KEU_RDATA_RST  = 8'h00;
  localparam logic [7:0]              KEU_ZERO_BYTE  = 8'h00;

  // Synchroniser depth for pin inputs
  localparam int KEU_SYNC_STAGES = 2;

  // One register-port access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } keu_bus_s;

  // Per-source request lines towards the processor
  typedef struct packed {
    logic ext_req;
    logic key_req;
  } keu_req_s;

endpackage

`default_nettype wire

// ### core/keu_sync.sv
// Two-flop synchroniser for a group of pin inputs
`default_nettype none

module keu_sync #(
  parameter int          WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic             clock_i, // Bus clock
  input  wire logic             rst_n_i, // Async reset, active low
  input  wire logic [WIDTH-1:0] async_i, // Raw pin levels
  output logic      [WIDTH-1:0] sync_o   // Synchronised levels
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // First stage feeds the second only
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

`default_nettype wire

// ### core/keu_latch.sv
// One interrupt request latch with edge-only or edge-plus-level clearing
`default_nettype none

module keu_latch (
  input  wire logic clock_i, // Bus clock
  input  wire logic rst_n_i, // Async reset, active low
  input  wire logic low_i,   // Synchronised: some enabled pin low
  input  wire logic mode_i,  // 1 = edge plus level, 0 = edge only
  input  wire logic ack_i,   // Acknowledge pulse, software or vector
  output logic      flag_o   // Latched request
);

  logic low_r;
  logic flag_r;
  logic acked_r;
  logic flag_nxt;
  logic acked_nxt;

  // Any low after all high sets the latch
  wire fall_w     = low_i & ~low_r;
  wire ack_seen_w = ack_i | acked_r;
  // Edge mode: ack clears at once; level mode: ack and pin high, any order
  wire clr_w      = mode_i ? (ack_seen_w & ~low_i) : ack_i;

  // Set wins over a same-cycle clear
  assign flag_nxt  = fall_w | (flag_r & ~clr_w);
  assign acked_nxt = flag_nxt & mode_i & ~fall_w & ack_seen_w;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_r   <= 1'b0;
      flag_r  <= 1'b0;
      acked_r <= 1'b0;
    end else begin
      low_r   <= low_i;
      flag_r  <= flag_nxt;
      acked_r <= acked_nxt;
    end
  end

  assign flag_o = flag_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_fall_sets;
    !low_i ##1 low_i |=> flag_o;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge did not latch");

  property p_edge_ack_clears;
    flag_o && !mode_i && ack_i && !(low_i && !low_r) |=> !flag_o;
  endproperty
  a_edge_ack_clears: assert property (p_edge_ack_clears) else $error("edge ack left latch set");

  property p_level_holds_low;
    flag_o && mode_i && low_i |=> flag_o;
  endproperty
  a_level_holds_low: assert property (p_level_holds_low) else $error("level latch cleared while low");

  property p_level_ack_then_high;
    flag_o && mode_i && ack_i && low_i && low_r ##1 (mode_i && !ack_i && !low_i && $stable(mode_i)) |=> !flag_o;
  endproperty
  a_level_ack_then_high: assert property (p_level_ack_then_high) else $error("level latch not cleared");

endmodule

`default_nettype wire

// ### core/keu_top.sv
// External pin and keypad interrupt unit: registers, latches, masks, wake logic
//
// What this block does
// - Status bit 7 shows external request pending
// - Writing ext ack clears latch, reads 0
// - External mask 1 blocks external requests
// - External trigger: 1 edge+level, 0 edge
// - Keypad pending flag readable, reset clears
// - Writing keypad ack clears request, reads 0
// - Keypad mask 1 blocks keypad requests
// - Keypad trigger: 1 edge+level, 0 edge
// - Reset clears all six pin enables
// - Enable bit arms pin and its pullup
// - Enabled pin forced to input direction
// - Unmasked request wakes from wait mode
// - Unmasked pin low wakes from stop
// - Latch on any low after all high
// - Level mode clears on ack plus high
// - Vector fetch acknowledges the pending request
// - Masks gate requests, never the flags
//
// The address-and-strobe port was chosen for this implementation.
`default_nettype none

module keu_top
  import keu_pkg::*;
(
  input  wire logic                      clock_i,      // Bus clock, 10 MHz
  input  wire logic                      rst_n_i,      // Async reset, active low
  input  wire keu_pkg::keu_bus_s         bus_i,        // Register access
  output logic [7:0]                     rdata_o,      // Read data, cycle after read
  input  wire logic                      ext_pin_n_i,  // External interrupt pin, active low
  input  wire logic [keu_pkg::KEU_KEY_PINS-1:0] key_pin_i, // Keypad pins 6..1 as 5..0
  input  wire logic                      vec_fetch_i,  // Interrupt vector fetch pulse
  input  wire logic                      stop_i,       // Processor in stop mode
  output keu_pkg::keu_req_s              req_o,        // Unmasked requests to priority logic
  output logic                           wake_o,       // Wait-mode wake request
  output logic                           stop_wake_o,  // Stop-mode wake, async set
  output logic [keu_pkg::KEU_KEY_PINS-1:0] pullup_en_o, // Pin pullup enables
  output logic [keu_pkg::KEU_KEY_PINS-1:0] force_in_o  // Pin forced to input
);

  import keu_pkg::*;

  // Control and status state
  logic                    ext_mask_r;
  logic                    ext_trig_r;
  logic                    key_mask_r;
  logic                    key_trig_r;
  logic [KEU_KEY_PINS-1:0] pin_en_r;
  logic [7:0]              rdata_r;
  keu_req_s                req_r;
  logic                    wake_r;
  logic                    stop_wake_r;

  logic                    ext_flag;
  logic                    key_flag;
  logic                    ext_sync;
  logic [KEU_KEY_PINS-1:0] key_sync;
  logic [7:0]              rdata_nxt;
  keu_req_s                req_nxt;

  // Address decode
  wire scr_hit_w  = (bus_i.addr == KEU_SCR_OFS);
  wire en_hit_w   = (bus_i.addr == KEU_PIN_EN_OFS);
  wire scr_wr_w   = bus_i.wr & scr_hit_w;
  wire en_wr_w    = bus_i.wr & en_hit_w;

  // Software acknowledges
  wire ext_sw_ack_w = scr_wr_w & bus_i.wdata[KEU_SCR_EXT_ACK_BIT];
  wire key_sw_ack_w = scr_wr_w & bus_i.wdata[KEU_SCR_KEY_ACK_BIT];

  // Vector fetch acknowledges the request the processor is serving; external first
  wire ext_vec_ack_w = vec_fetch_i & req_r.ext_req;
  wire key_vec_ack_w = vec_fetch_i & ~req_r.ext_req & req_r.key_req;

  // Pin synchronisers; idle level is high
  keu_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) u_ext_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i (ext_pin_n_i),
    .sync_o  (ext_sync)
  );

  keu_sync #(
    .WIDTH   (KEU_KEY_PINS),
    .RST_VAL ({KEU_KEY_PINS{1'b1}})
  ) u_key_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i (key_pin_i),
    .sync_o  (key_sync)
  );

  // Disabled pins are ignored; keypad low means any enabled pin low
  wire ext_low_w = ~ext_sync;
  wire key_low_w = |(~key_sync & pin_en_r);

  keu_latch u_ext_latch (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .low_i   (ext_low_w),
    .mode_i  (ext_trig_r),
    .ack_i   (ext_sw_ack_w | ext_vec_ack_w),
    .flag_o  (ext_flag)
  );

  keu_latch u_key_latch (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .low_i   (key_low_w),
    .mode_i  (key_trig_r),
    .ack_i   (key_sw_ack_w | key_vec_ack_w),
    .flag_o  (key_flag)
  );

  // Masks gate the forwarded requests and, below, the stop wake; never the flags
  assign req_nxt.ext_req = ext_flag & ~ext_mask_r;
  assign req_nxt.key_req = key_flag & ~key_mask_r;

  // Read mux; ack bits and unmapped addresses read zero
  wire [7:0] scr_rd_w = {ext_flag,
                         1'b0,
                         ext_mask_r,
                         ext_trig_r,
                         key_flag,
                         1'b0,
                         key_mask_r,
                         key_trig_r};
  wire [7:0] en_rd_w  = {1'b0, pin_en_r, 1'b0};

  assign rdata_nxt = !bus_i.rd ? KEU_ZERO_BYTE :
                     scr_hit_w ? scr_rd_w :
                     en_hit_w  ? en_rd_w  : KEU_ZERO_BYTE;

  // Control register writes
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_mask_r <= KEU_CTRL_RST;
      ext_trig_r <= KEU_CTRL_RST;
      key_mask_r <= KEU_CTRL_RST;
      key_trig_r <= KEU_CTRL_RST;
    end else if (scr_wr_w) begin
      ext_mask_r <= bus_i.wdata[KEU_SCR_EXT_MASK_BIT];
      ext_trig_r <= bus_i.wdata[KEU_SCR_EXT_TRIG_BIT];
      key_mask_r <= bus_i.wdata[KEU_SCR_KEY_MASK_BIT];
      key_trig_r <= bus_i.wdata[KEU_SCR_KEY_TRIG_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_en_r <= KEU_PIN_EN_RST;
    end else if (en_wr_w) begin
      pin_en_r <= bus_i.wdata[KEU_PIN_EN_MSB:KEU_PIN_EN_LSB];
    end
  end

  // Read data, requests and wait wake
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= KEU_RDATA_RST;
      req_r   <= '0;
      wake_r  <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      req_r   <= req_nxt;
      wake_r  <= req_nxt.ext_req | req_nxt.key_req;
    end
  end

  // Stop wake works on raw pins with no clock edge needed; a glitch
  // on an enabled pin can wake the part, which is harmless
  wire stop_raw_w = stop_i & ((~ext_pin_n_i & ~ext_mask_r) |
                              ((|(~key_pin_i & pin_en_r)) & ~key_mask_r));

  always_ff @(posedge clock_i or negedge rst_n_i or posedge stop_raw_w) begin
    if (!rst_n_i) begin
      stop_wake_r <= 1'b0;
    end else if (stop_raw_w) begin
      stop_wake_r <= 1'b1;
    end else if (!stop_i) begin
      stop_wake_r <= 1'b0;
    end
  end

  assign rdata_o     = rdata_r;
  assign req_o       = req_r;
  assign wake_o      = wake_r;
  assign stop_wake_o = stop_wake_r;
  assign pullup_en_o = pin_en_r;
  // Port logic must still read the pin only when its direction bit is 0
  assign force_in_o  = pin_en_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  property p_ext_flag_read;
    bus_i.rd && scr_hit_w |=> rdata_o[KEU_SCR_EXT_FLAG_BIT] == $past(ext_flag);
  endproperty
  a_ext_flag_read: assert property (p_ext_flag_read) else $error("pending flag read wrong");

  property p_ack_reads_zero;
    bus_i.rd && scr_hit_w |=> !rdata_o[KEU_SCR_EXT_ACK_BIT] && !rdata_o[KEU_SCR_KEY_ACK_BIT];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read as one");

  property p_ext_mask_blocks;
    ext_mask_r ##1 ext_mask_r |-> !req_o.ext_req;
  endproperty
  a_ext_mask_blocks: assert property (p_ext_mask_blocks) else $error("masked external request");

  property p_key_mask_blocks;
    key_mask_r ##1 key_mask_r |-> !req_o.key_req && (req_o.ext_req || !wake_o);
  endproperty
  a_key_mask_blocks: assert property (p_key_mask_blocks) else $error("masked keypad request");

  property p_flag_ignores_mask;
    bus_i.rd && scr_hit_w && key_flag && key_mask_r |=> rdata_o[KEU_SCR_KEY_FLAG_BIT];
  endproperty
  a_flag_ignores_mask: assert property (p_flag_ignores_mask) else $error("mask hid keypad flag");

  property p_enable_write;
    en_wr_w |=> pullup_en_o == $past(bus_i.wdata[KEU_PIN_EN_MSB:KEU_PIN_EN_LSB]) && force_in_o == pullup_en_o;
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("pin enable not stored");

  property p_wait_wake;
    ext_flag && !ext_mask_r |=> wake_o && req_o.ext_req;
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("unmasked request did not wake");

  property p_stop_wake;
    stop_i && !ext_mask_r && !ext_pin_n_i |=> stop_wake_o;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake missing");

  property p_trig_write;
    scr_wr_w |=> ext_trig_r == $past(bus_i.wdata[KEU_SCR_EXT_TRIG_BIT])
             && key_trig_r == $past(bus_i.wdata[KEU_SCR_KEY_TRIG_BIT]);
  endproperty
  a_trig_write: assert property (p_trig_write) else $error("trigger select not stored");

  property p_vec_clears_edge;
    vec_fetch_i && req_r.ext_req && !ext_trig_r && ext_flag && !ext_low_w ##1 !ext_low_w |-> !ext_flag;
  endproperty
  a_vec_clears_edge: assert property (p_vec_clears_edge) else $error("vector fetch did not clear");

  property p_key_flag_read;
    bus_i.rd && scr_hit_w |=> rdata_o[KEU_SCR_KEY_FLAG_BIT] == $past(key_flag);
  endproperty
  a_key_flag_read: assert property (p_key_flag_read) else $error("keypad flag read wrong");

  property p_mask_read;
    bus_i.rd && scr_hit_w |=> rdata_o[KEU_SCR_EXT_MASK_BIT] == $past(ext_mask_r)
             && rdata_o[KEU_SCR_KEY_MASK_BIT] == $past(key_mask_r);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask bit read wrong");

  property p_trig_read;
    bus_i.rd && scr_hit_w |=> rdata_o[KEU_SCR_EXT_TRIG_BIT] == $past(ext_trig_r)
             && rdata_o[KEU_SCR_KEY_TRIG_BIT] == $past(key_trig_r);
  endproperty
  a_trig_read: assert property (p_trig_read) else $error("trigger select read wrong");

  property p_mask_write;
    scr_wr_w |=> ext_mask_r == $past(bus_i.wdata[KEU_SCR_EXT_MASK_BIT])
             && key_mask_r == $past(bus_i.wdata[KEU_SCR_KEY_MASK_BIT]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask bit not stored");

  property p_ext_sw_ack_clears;
    ext_sw_ack_w && !ext_trig_r && !ext_low_w |=> !ext_flag;
  endproperty
  a_ext_sw_ack_clears: assert property (p_ext_sw_ack_clears) else $error("external ack left flag set");

  property p_key_sw_ack_clears;
    key_sw_ack_w && !key_trig_r && !key_low_w |=> !key_flag;
  endproperty
  a_key_sw_ack_clears: assert property (p_key_sw_ack_clears) else $error("keypad ack left flag set");

  property p_enable_read;
    bus_i.rd && en_hit_w |=> rdata_o == {1'b0, $past(pin_en_r), 1'b0};
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("pin enable read wrong");

  property p_disabled_pins_quiet;
    pin_en_r == KEU_PIN_EN_RST && !key_flag |=> !key_flag;
  endproperty
  a_disabled_pins_quiet: assert property (p_disabled_pins_quiet) else $error("disabled pins set flag");

  property p_ext_fall_latency;
    ext_pin_n_i ##1 !ext_pin_n_i |-> ##3 ext_flag;
  endproperty
  a_ext_fall_latency: assert property (p_ext_fall_latency) else $error("external edge not latched");

  property p_key_low_ignored;
    !key_flag && key_low_w && $past(key_low_w) |=> !key_flag;
  endproperty
  a_key_low_ignored: assert property (p_key_low_ignored) else $error("edge latched while pin low");

  property p_ext_level_holds;
    ext_flag && ext_trig_r && ext_low_w |=> ext_flag;
  endproperty
  a_ext_level_holds: assert property (p_ext_level_holds) else $error("external level flag lost");

  property p_key_level_holds;
    key_flag && key_trig_r && key_low_w |=> key_flag;
  endproperty
  a_key_level_holds: assert property (p_key_level_holds) else $error("keypad level flag lost");

  property p_vec_clears_key;
    vec_fetch_i && !req_r.ext_req && req_r.key_req && !key_trig_r
    && !(key_low_w && !$past(key_low_w)) |=> !key_flag;
  endproperty
  a_vec_clears_key: assert property (p_vec_clears_key) else $error("vector fetch left keypad set");

  property p_ext_flag_ignores_mask;
    bus_i.rd && scr_hit_w && ext_flag && ext_mask_r |=> rdata_o[KEU_SCR_EXT_FLAG_BIT];
  endproperty
  a_ext_flag_ignores_mask: assert property (p_ext_flag_ignores_mask) else $error("mask hid external flag");

  property p_key_wait_wake;
    key_flag && !key_mask_r |=> wake_o && req_o.key_req;
  endproperty
  a_key_wait_wake: assert property (p_key_wait_wake) else $error("keypad request did not wake");

  property p_idle_no_wake;
    !ext_flag && !key_flag |=> !wake_o;
  endproperty
  a_idle_no_wake: assert property (p_idle_no_wake) else $error("wake without request");

  property p_key_stop_wake;
    stop_i && !key_mask_r && (|(~key_pin_i & pin_en_r)) |=> stop_wake_o;
  endproperty
  a_key_stop_wake: assert property (p_key_stop_wake) else $error("keypad stop wake missing");

  property p_stop_wake_clears;
    !stop_i ##1 !stop_i |-> !stop_wake_o;
  endproperty
  a_stop_wake_clears: assert property (p_stop_wake_clears) else $error("stop wake stuck");

endmodule

`default_nettype wire

// ### sim/keu_pad_model.sv
// Keypad switches and external interrupt source facing the unit's pins
`default_nettype none

module keu_pad_model (
  input  wire logic       clock_i,     // Bus clock
  input  wire logic [5:0] press_i,     // Keys held closed, pull pin low
  input  wire logic       ext_low_i,   // External source asserting its line
  input  wire logic [5:0] pullup_en_i, // Pullups switched on by the unit
  input  wire logic [5:0] drive_hi_i,  // Port drives pin high before enable
  output logic      [5:0] key_pin_o,   // Keypad pin levels
  output logic            ext_pin_n_o  // External line, driven both ways
);
  timeunit 1ns;
  timeprecision 1ps;

  logic tgl_r = 1'b0;

  // A floating pin must not look like a clean high, so it wobbles
  always @(posedge clock_i) begin
    tgl_r <= ~tgl_r;
  end

  always_comb begin
    for (int k = 0; k < 6; k++) begin
      key_pin_o[k] = press_i[k] ? 1'b0 : ((pullup_en_i[k] | drive_hi_i[k]) ? 1'b1 : tgl_r);
    end
  end

  assign ext_pin_n_o = ~ext_low_i;
endmodule

`default_nettype wire

// ### sim/keu_top_tb.sv
// Self-checking testbench of the external and keypad interrupt unit
`default_nettype none

module keu_top_tb;
  import keu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clock_i = 1'b0;
  logic       rst_n_i = 1'b0;
  keu_bus_s   bus     = '0;
  logic [7:0] rdata;
  logic       ext_pin_n;
  logic [5:0] key_pin;
  logic       vec     = 1'b0;
  logic       stop    = 1'b0;
  keu_req_s   req;
  logic       wake;
  logic       stop_wake;
  logic [5:0] pullup_en;
  logic [5:0] force_in;
  logic [5:0] press   = 6'h00;
  logic [5:0] drive_hi = 6'h00;
  logic       ext_low = 1'b0;
  int         failures   = 0;
  int         n_compared = 0;

  always #50 clock_i = ~clock_i;

  keu_top keu_top_i (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .bus_i       (bus),
    .rdata_o     (rdata),
    .ext_pin_n_i (ext_pin_n),
    .key_pin_i   (key_pin),
    .vec_fetch_i (vec),
    .stop_i      (stop),
    .req_o       (req),
    .wake_o      (wake),
    .stop_wake_o (stop_wake),
    .pullup_en_o (pullup_en),
    .force_in_o  (force_in)
  );

  keu_pad_model keu_pad_model_i (
    .clock_i     (clock_i),
    .press_i     (press),
    .ext_low_i   (ext_low),
    .pullup_en_i (pullup_en),
    .drive_hi_i  (drive_hi),
    .key_pin_o   (key_pin),
    .ext_pin_n_o (ext_pin_n)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // Pin change to latched flag and request takes four edges
  task automatic settle();
    repeat (5) @(posedge clock_i);
    #1;
  endtask

  task automatic t_reset();
    rd(KEU_SCR_OFS, 8'h00);
    rd(KEU_PIN_EN_OFS, 8'h00);
    rd(8'h20, 8'h00);
    chk({2'b00, pullup_en}, 8'h00);
    chk({2'b00, force_in}, 8'h00);
    chk({6'h00, req}, 8'h00);
  endtask

  // Mask, enable, acknowledge, unmask: wobbling pins must leave no flag
  task automatic t_enable();
    wr(KEU_SCR_OFS, 8'h02);
    wr(KEU_PIN_EN_OFS, 8'hff);
    rd(KEU_PIN_EN_OFS, 8'h7e);
    chk({2'b00, pullup_en}, 8'h3f);
    chk({2'b00, force_in}, 8'h3f);
    wr(KEU_SCR_OFS, 8'h06);
    wr(KEU_SCR_OFS, 8'h00);
    rd(KEU_SCR_OFS, 8'h00);
  endtask

  task automatic t_ext_edge();
    @(posedge clock_i) ext_low <= 1'b1;
    settle();
    rd(KEU_SCR_OFS, 8'h80);
    chk({6'h00, req}, 8'h02);
    chk({7'h00, wake}, 8'h01);
    wr(KEU_SCR_OFS, 8'h40);
    rd(KEU_SCR_OFS, 8'h00);
    chk({6'h00, req}, 8'h00);
    wr(KEU_SCR_OFS, 8'h20);
    @(posedge clock_i) ext_low <= 1'b0;
    settle();
    @(posedge clock_i) ext_low <= 1'b1;
    settle();
    rd(KEU_SCR_OFS, 8'ha0);
    chk({6'h00, req}, 8'h00);
    chk({7'h00, wake}, 8'h00);
    wr(KEU_SCR_OFS, 8'h40);
    @(posedge clock_i) ext_low <= 1'b0;
    settle();
    @(posedge clock_i) ext_low <= 1'b1;
    settle();
    @(posedge clock_i) ext_low <= 1'b0;
    settle();
    chk({6'h00, req}, 8'h02);
    @(posedge clock_i) vec <= 1'b1;
    @(posedge clock_i) vec <= 1'b0;
    rd(KEU_SCR_OFS, 8'h00);
  endtask

  task automatic t_ext_level();
    wr(KEU_SCR_OFS, 8'h10);
    @(posedge clock_i) ext_low <= 1'b1;
    settle();
    wr(KEU_SCR_OFS, 8'h50);
    rd(KEU_SCR_OFS, 8'h90);
    chk({6'h00, req}, 8'h02);
    @(posedge clock_i) ext_low <= 1'b0;
    settle();
    rd(KEU_SCR_OFS, 8'h10);
    wr(KEU_SCR_OFS, 8'h00);
  endtask

  task automatic t_key_edge();
    @(posedge clock_i) press <= 6'h01;
    settle();
    rd(KEU_SCR_OFS, 8'h08);
    chk({6'h00, req}, 8'h01);
    wr(KEU_SCR_OFS, 8'h04);
    @(posedge clock_i) press <= 6'h09;
    settle();
    rd(KEU_SCR_OFS, 8'h00);
    @(posedge clock_i) press <= 6'h00;
    settle();
    @(posedge clock_i) press <= 6'h08;
    settle();
    chk({6'h00, req}, 8'h01);
    @(posedge clock_i) vec <= 1'b1;
    @(posedge clock_i) vec <= 1'b0;
    settle();
    rd(KEU_SCR_OFS, 8'h00);
    @(posedge clock_i) press <= 6'h00;
  endtask

  task automatic t_key_level();
    wr(KEU_SCR_OFS, 8'h03);
    @(posedge clock_i) press <= 6'h02;
    settle();
    rd(KEU_SCR_OFS, 8'h0b);
    chk({6'h00, req}, 8'h00);
    wr(KEU_SCR_OFS, 8'h07);
    rd(KEU_SCR_OFS, 8'h0b);
    @(posedge clock_i) press <= 6'h00;
    settle();
    rd(KEU_SCR_OFS, 8'h03);
    wr(KEU_SCR_OFS, 8'h00);
  endtask

  // Pins held high by the port before enabling: no false edge, no ack
  task automatic t_drive_init();
    @(posedge clock_i) drive_hi <= 6'h3f;
    wr(KEU_PIN_EN_OFS, 8'h00);
    settle();
    wr(KEU_PIN_EN_OFS, 8'h7e);
    settle();
    @(posedge clock_i) drive_hi <= 6'h00;
    rd(KEU_SCR_OFS, 8'h00);
    chk({6'h00, req}, 8'h00);
  endtask

  // Keypad source first, then the external pin
  task automatic t_stop();
    int n;
    for (int src = 0; src < 2; src++) begin
      @(posedge clock_i) stop <= 1'b1;
      @(posedge clock_i) begin
        press   <= (src == 0) ? 6'h04 : 6'h00;
        ext_low <= (src == 1);
      end
      n = 0;
      while (stop_wake !== 1'b1 && n < 10) begin
        @(posedge clock_i);
        n++;
      end
      chk({7'h00, stop_wake}, 8'h01);
      @(posedge clock_i) stop <= 1'b0;
      press   <= 6'h00;
      ext_low <= 1'b0;
      settle();
      chk({7'h00, stop_wake}, 8'h00);
    end
    wr(KEU_SCR_OFS, 8'h44);
    rd(KEU_SCR_OFS, 8'h00);
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_enable();
    t_ext_edge();
    t_ext_level();
    t_key_edge();
    t_key_level();
    t_drive_init();
    t_stop();
    finish_test();
  end
endmodule

`default_nettype wire
